// [logic/stef_pkg.sv]
/*
  shared constants of the status transition event filter: register
  selects, bit positions of both status groups, masks, limits, presets.
  assumes nothing beyond a SystemVerilog compiler.
*/
package stef_pkg;
  localparam int REG_W = 16;
  localparam int SEL_W = 4;

  // register select codes on the command port
  localparam logic [3:0] SEL_FAULT_COND = 4'h0;
  localparam logic [3:0] SEL_FAULT_EVENT = 4'h1;
  localparam logic [3:0] SEL_FAULT_ENAB = 4'h2;
  localparam logic [3:0] SEL_FAULT_FALL = 4'h3;
  localparam logic [3:0] SEL_FAULT_RISE = 4'h4;
  localparam logic [3:0] SEL_RUN_COND = 4'h5;
  localparam logic [3:0] SEL_RUN_EVENT = 4'h6;
  localparam logic [3:0] SEL_RUN_ENAB = 4'h7;
  localparam logic [3:0] SEL_RUN_FALL = 4'h8;
  localparam logic [3:0] SEL_RUN_RISE = 4'h9;

  // fault group bit positions
  localparam int FB_HIGH_VOLTAGE = 0;
  localparam int FB_CURRENT_LIMIT = 1;
  localparam int FB_BLOWN_FUSE = 2;
  localparam int FB_HEAT = 4;
  localparam int FB_REMOTE_INHIBIT = 9;
  localparam int FB_UNREGULATED = 10;
  localparam int FB_MEAS_OVERLOAD = 14;

  // run group bit positions
  localparam int RB_CAL_BUSY = 0;
  localparam int RB_AWAIT_TRIG = 5;
  localparam int RB_VOLT_HELD = 8;
  localparam int RB_CURR_POS = 10;
  localparam int RB_CURR_NEG = 11;

  localparam logic [15:0] FAULT_MASK = 16'h4617;
  localparam logic [15:0] RUN_MASK = 16'h0d21;

  // largest accepted values for writes
  localparam logic [15:0] EDGE_SEL_LIMIT = 16'h7fd7;
  localparam logic [15:0] FAULT_ENAB_LIMIT = 16'h7fff;
  localparam logic [15:0] RUN_ENAB_LIMIT = 16'h7fd7;

  localparam logic [15:0] RISE_PRESET = 16'h7fd7;
  localparam logic [15:0] FALL_PRESET = 16'h0000;
  localparam logic [15:0] ENAB_PRESET = 16'h0000;

  // status byte positions of the two summary bits
  localparam int SB_FAULT_SUMMARY = 3;
  localparam int SB_RUN_SUMMARY = 7;
endpackage : stef_pkg

// [logic/stef_group_if.sv]
/*
  carrier between the top and one status group instance.
  assumes the top drives the ctrl side and the group the grp side.
*/
`timescale 1ns/1ps
interface stef_group_if;
  logic wr_fall;
  logic wr_rise;
  logic wr_enab;
  logic [15:0] wdata;
  logic preset;
  logic clr_event;
  logic [15:0] cond;
  logic [15:0] fall_sel;
  logic [15:0] rise_sel;
  logic [15:0] enab;
  logic [15:0] event_bits;
  logic summary;

  modport ctrl (
    output wr_fall, wr_rise, wr_enab, wdata, preset, clr_event, cond,
    input fall_sel, rise_sel, enab, event_bits, summary
  );
  modport grp (
    input wr_fall, wr_rise, wr_enab, wdata, preset, clr_event, cond,
    output fall_sel, rise_sel, enab, event_bits, summary
  );
endinterface : stef_group_if

// [logic/stef_group.sv]
/*
  one status group: edge select filters, sticky event register,
  enable mask and summary bit.
  assumes cond is already synchronous to mclk and that clr_event and the
  write strobes are one-cycle pulses from the top.
*/
`timescale 1ns/1ps
module stef_group #(
  parameter logic [15:0] DEF_MASK = 16'h0000,
  parameter logic [15:0] ENAB_LIMIT = 16'h7fff
) (
  input wire logic mclk,
  input wire logic sys_rst,
  stef_group_if.grp gi
);
  import stef_pkg::*;

  typedef struct packed {
    logic [15:0] fall;
    logic [15:0] rise;
    logic [15:0] enab;
    logic [15:0] event_bits;
    logic [15:0] prev;
  } stef_grp_state_t;

  stef_grp_state_t r_reg;
  stef_grp_state_t r_next;
  logic [15:0] hits;

  always_comb begin
    r_next = r_reg;
    r_next.prev = gi.cond;
    hits = ((~r_reg.prev & gi.cond & r_reg.rise) | (r_reg.prev & ~gi.cond & r_reg.fall)) & DEF_MASK;
    // a latch in the clearing cycle is ORed in after the clear, so it survives
    r_next.event_bits = (gi.clr_event ? 16'h0000 : r_reg.event_bits) | hits;
    if (gi.preset) begin
      r_next.rise = RISE_PRESET & DEF_MASK;
      r_next.fall = FALL_PRESET;
      r_next.enab = ENAB_PRESET;
    end else begin
      // out-of-range values are refused and the old setting kept
      if (gi.wr_fall && gi.wdata <= EDGE_SEL_LIMIT) begin
        r_next.fall = gi.wdata & DEF_MASK;
      end
      if (gi.wr_rise && gi.wdata <= EDGE_SEL_LIMIT) begin
        r_next.rise = gi.wdata & DEF_MASK;
      end
      if (gi.wr_enab && gi.wdata <= ENAB_LIMIT) begin
        r_next.enab = gi.wdata & DEF_MASK;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      r_reg.fall <= FALL_PRESET;
      r_reg.rise <= RISE_PRESET & DEF_MASK;
      r_reg.enab <= ENAB_PRESET;
      r_reg.event_bits <= 16'h0000;
      r_reg.prev <= 16'h0000;
    end else begin
      r_reg <= r_next;
    end
  end

  assign gi.fall_sel = r_reg.fall;
  assign gi.rise_sel = r_reg.rise;
  assign gi.enab = r_reg.enab;
  assign gi.event_bits = r_reg.event_bits;
  assign gi.summary = |(r_reg.event_bits & r_reg.enab);
endmodule : stef_group

// [logic/stef_top.sv]
/*
  status transition event filter: fault and run status groups behind a
  register-select command port, with the two status byte summary bits.
  assumes status pins are asynchronous to mclk and that the command
  port is driven synchronously by the command interpreter.
*/
// Functional notes
// - falling select latches event on 1-to-0
// - rising select latches event on 0-to-1
// - both selects latch either direction
// - neither select never latches the event
// - fault event read-only, cleared by read
// - fault condition reads live status
// - status bit 3 ORs enabled fault events
// - preset falling 0, rising 32727; limit 32727
// - fault bits 0,1,2: voltage, current, fuse
// - fault bits 4,9,10: heat, inhibit, unregulated
// - fault bit 14 overload; others unused
// - edge selects writable and read back
// - run bits 0,5,8,10,11 defined
// - status bit 7 ORs enabled run events
// - run event read then cleared
// - preset sets rising, clears falling, enables
`timescale 1ns/1ps
module stef_top (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic high_voltage_trip,
  input wire logic current_limit_trip,
  input wire logic blown_fuse,
  input wire logic heat_trip,
  input wire logic remote_inhibit,
  input wire logic output_unregulated,
  input wire logic meas_overload,
  input wire logic cal_busy,
  input wire logic awaiting_trigger,
  input wire logic voltage_held_mode,
  input wire logic current_held_positive,
  input wire logic current_held_negative,
  input wire logic [stef_pkg::SEL_W-1:0] cmd_sel,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [stef_pkg::REG_W-1:0] cmd_wdata,
  input wire logic stat_preset,
  output logic [stef_pkg::REG_W-1:0] rsp_rdata,
  output logic rsp_valid,
  output logic fault_group_summary,
  output logic run_group_summary
);
  import stef_pkg::*;

  typedef struct packed {
    logic [15:0] f_s1;
    logic [15:0] f_s2;
    logic [15:0] f_s3;
    logic [15:0] r_s1;
    logic [15:0] r_s2;
    logic [15:0] r_s3;
    logic [15:0] f_cond;
    logic [15:0] r_cond;
    logic [15:0] rdata;
    logic rvalid;
  } stef_top_state_t;

  stef_top_state_t s_reg;
  stef_top_state_t s_next;
  logic [15:0] fault_pins;
  logic [15:0] run_pins;

  stef_group_if fault_if ();
  stef_group_if run_if ();

  // a synchronised bit is accepted once the second and third stages agree
  function automatic logic [15:0] stef_settle(input logic [15:0] cur, input logic [15:0] s2,
                                              input logic [15:0] s3);
    // hold the accepted value while the stages disagree, follow them once they agree
    stef_settle = (cur & (s2 ^ s3)) | (s2 & (s2 ~^ s3));
  endfunction : stef_settle

  always_comb begin
    fault_pins = 16'h0000;
    fault_pins[FB_HIGH_VOLTAGE] = high_voltage_trip;
    fault_pins[FB_CURRENT_LIMIT] = current_limit_trip;
    fault_pins[FB_BLOWN_FUSE] = blown_fuse;
    fault_pins[FB_HEAT] = heat_trip;
    fault_pins[FB_REMOTE_INHIBIT] = remote_inhibit;
    fault_pins[FB_UNREGULATED] = output_unregulated;
    fault_pins[FB_MEAS_OVERLOAD] = meas_overload;
    run_pins = 16'h0000;
    run_pins[RB_CAL_BUSY] = cal_busy;
    run_pins[RB_AWAIT_TRIG] = awaiting_trigger;
    run_pins[RB_VOLT_HELD] = voltage_held_mode;
    run_pins[RB_CURR_POS] = current_held_positive;
    run_pins[RB_CURR_NEG] = current_held_negative;
  end

  always_comb begin
    s_next = s_reg;
    s_next.f_s1 = fault_pins;
    s_next.f_s2 = s_reg.f_s1;
    s_next.f_s3 = s_reg.f_s2;
    s_next.r_s1 = run_pins;
    s_next.r_s2 = s_reg.r_s1;
    s_next.r_s3 = s_reg.r_s2;
    s_next.f_cond = stef_settle(s_reg.f_cond, s_reg.f_s2, s_reg.f_s3) & FAULT_MASK;
    s_next.r_cond = stef_settle(s_reg.r_cond, s_reg.r_s2, s_reg.r_s3) & RUN_MASK;
    s_next.rvalid = cmd_rd;
    if (cmd_rd) begin
      unique case (cmd_sel)
        SEL_FAULT_COND: s_next.rdata = s_reg.f_cond;
        SEL_FAULT_EVENT: s_next.rdata = fault_if.event_bits;
        SEL_FAULT_ENAB: s_next.rdata = fault_if.enab;
        SEL_FAULT_FALL: s_next.rdata = fault_if.fall_sel;
        SEL_FAULT_RISE: s_next.rdata = fault_if.rise_sel;
        SEL_RUN_COND: s_next.rdata = s_reg.r_cond;
        SEL_RUN_EVENT: s_next.rdata = run_if.event_bits;
        SEL_RUN_ENAB: s_next.rdata = run_if.enab;
        SEL_RUN_FALL: s_next.rdata = run_if.fall_sel;
        SEL_RUN_RISE: s_next.rdata = run_if.rise_sel;
        default: s_next.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // condition registers are read-only: no write strobe reaches them
  assign fault_if.cond = s_reg.f_cond;
  assign fault_if.wdata = cmd_wdata;
  assign fault_if.preset = stat_preset;
  assign fault_if.wr_fall = cmd_wr && cmd_sel == SEL_FAULT_FALL;
  assign fault_if.wr_rise = cmd_wr && cmd_sel == SEL_FAULT_RISE;
  assign fault_if.wr_enab = cmd_wr && cmd_sel == SEL_FAULT_ENAB;
  assign fault_if.clr_event = cmd_rd && cmd_sel == SEL_FAULT_EVENT;

  assign run_if.cond = s_reg.r_cond;
  assign run_if.wdata = cmd_wdata;
  assign run_if.preset = stat_preset;
  assign run_if.wr_fall = cmd_wr && cmd_sel == SEL_RUN_FALL;
  assign run_if.wr_rise = cmd_wr && cmd_sel == SEL_RUN_RISE;
  assign run_if.wr_enab = cmd_wr && cmd_sel == SEL_RUN_ENAB;
  assign run_if.clr_event = cmd_rd && cmd_sel == SEL_RUN_EVENT;

  stef_group #(
    .DEF_MASK(FAULT_MASK),
    .ENAB_LIMIT(FAULT_ENAB_LIMIT)
  ) u_fault (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .gi(fault_if)
  );

  stef_group #(
    .DEF_MASK(RUN_MASK),
    .ENAB_LIMIT(RUN_ENAB_LIMIT)
  ) u_run (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .gi(run_if)
  );

  assign rsp_rdata = s_reg.rdata;
  assign rsp_valid = s_reg.rvalid;
  assign fault_group_summary = fault_if.summary;
  assign run_group_summary = run_if.summary;
endmodule : stef_top

// [sim/stef_props.sv]
/*
  concurrent checks on the command port and the two summary bits of stef_top.
  assumes it is bound to stef_top and that everything runs on mclk.
*/
`timescale 1ns/1ps
module stef_props (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [stef_pkg::SEL_W-1:0] cmd_sel,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic stat_preset,
  input wire logic [stef_pkg::REG_W-1:0] rsp_rdata,
  input wire logic rsp_valid,
  input wire logic fault_group_summary,
  input wire logic run_group_summary
);
  import stef_pkg::*;
  logic touch;
  // a summary may only drop after a read, a mask write or a preset
  assign touch = cmd_rd | cmd_wr | stat_preset;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence rd_take;
    cmd_rd ##1 rsp_valid;
  endsequence
  rd_valid_a: assert property (cmd_rd |-> rd_take)
    else $error("read not answered");
  valid_pulse_a: assert property (!cmd_rd |=> !rsp_valid)
    else $error("valid without read");
  unmapped_zero_a: assert property (cmd_rd && cmd_sel > 4'h9 |=> rsp_rdata == 16'h0000)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!cmd_rd |=> $stable(rsp_rdata))
    else $error("read data moved");
  fault_unused_a: assert property (cmd_rd && cmd_sel < 4'h5 |=> (rsp_rdata & ~FAULT_MASK) == 16'h0000)
    else $error("fault unused bit set");
  run_unused_a: assert property (cmd_rd && cmd_sel inside {[4'h5:4'h9]} |=> (rsp_rdata & ~RUN_MASK) == 16'h0000)
    else $error("run unused bit set");
  fault_fall_a: assert property ($fell(fault_group_summary) |-> $past(touch) || $past(touch, 2))
    else $error("fault summary dropped alone");
  run_fall_a: assert property ($fell(run_group_summary) |-> $past(touch) || $past(touch, 2))
    else $error("run summary dropped alone");
endmodule : stef_props

// [sim/tb_top.sv]
/*
  self-checking bench for stef_top: reset values, writes, edge filters, summaries, preset.
  assumes the package and design files are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  import stef_pkg::*;
  logic mclk = 0, sys_rst = 1, cmd_wr = 0, cmd_rd = 0, stat_preset = 0;
  logic [3:0] cmd_sel = 0;
  logic [15:0] cmd_wdata = 0, fp = 0, rp = 0, rsp_rdata;
  logic rsp_valid, fault_group_summary, run_group_summary;
  logic [15:0] m [0:9];
  logic [15:0] exq [$];
  int bad_count = 0, samples_checked = 0, seed = 16337;
  always #20 mclk = ~mclk;
  stef_top uut (.mclk, .sys_rst, .high_voltage_trip(fp[0]), .current_limit_trip(fp[1]), .blown_fuse(fp[2]),
    .heat_trip(fp[4]), .remote_inhibit(fp[9]), .output_unregulated(fp[10]), .meas_overload(fp[14]),
    .cal_busy(rp[0]), .awaiting_trigger(rp[5]), .voltage_held_mode(rp[8]), .current_held_positive(rp[10]),
    .current_held_negative(rp[11]), .cmd_sel, .cmd_wr, .cmd_rd, .cmd_wdata, .stat_preset, .rsp_rdata,
    .rsp_valid, .fault_group_summary, .run_group_summary);
  function automatic logic [15:0] pv(int s);
    return (s % 5 == 4) ? RISE_PRESET & (s < 5 ? FAULT_MASK : RUN_MASK) : 16'h0;
  endfunction : pv
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  // one idle cycle between commands keeps every strobe a single pulse
  task automatic op(bit w, logic [3:0] s, logic [15:0] d);
    @(negedge mclk);
    cmd_sel = s;
    cmd_wdata = d;
    cmd_wr = w;
    cmd_rd = !w;
    if (!w) exq.push_back(s > 9 ? 16'h0 : m[s]);
    if (!w && (s == SEL_FAULT_EVENT || s == SEL_RUN_EVENT)) m[s] = 16'h0;
    @(negedge mclk);
    cmd_wr = 0;
    cmd_rd = 0;
  endtask : op
  task automatic rd(logic [3:0] s);
    op(0, s, 16'h0);
  endtask : rd
  task automatic wr(logic [3:0] s, logic [15:0] d);
    if (s inside {[4'h2:4'h4], [4'h7:4'h9]} &&
        d <= (s == 2 ? FAULT_ENAB_LIMIT : (s == 7 ? RUN_ENAB_LIMIT : EDGE_SEL_LIMIT)))
      m[s] = d & (s < 5 ? FAULT_MASK : RUN_MASK);
    op(1, s, d);
  endtask : wr
  task automatic sums;
    chk("fault summary", 16'(|(m[1] & m[2])), 16'(fault_group_summary));
    chk("run summary", 16'(|(m[6] & m[7])), 16'(run_group_summary));
  endtask : sums
  task automatic pins(bit g, logic [15:0] v);
    int b;
    logic [15:0] n;
    b = g ? 5 : 0;
    n = v & (g ? RUN_MASK : FAULT_MASK);
    m[b+1] |= (n & ~m[b] & m[b+4]) | (~n & m[b] & m[b+3]);
    m[b] = n;
    @(negedge mclk);
    if (g) rp = v;
    else fp = v;
    // covers the synchroniser, condition and event stages
    repeat (8) @(negedge mclk);
  endtask : pins
  always @(negedge mclk) if (rsp_valid === 1'b1) begin
    if (exq.size() == 0) chk("unexpected read", 16'h0, 16'hffff);
    else chk("read data", exq.pop_front(), rsp_rdata);
  end
  initial begin
    foreach (m[s]) m[s] = pv(s);
    repeat (5) @(negedge mclk);
    sys_rst = 0;
    for (int s = 0; s < 12; s++) rd(4'(s));
    $display("test reset values done");
    wr(SEL_FAULT_COND, 16'hffff);
    wr(SEL_FAULT_EVENT, 16'hffff);
    wr(SEL_RUN_RISE, 16'h7fd8);
    wr(SEL_FAULT_ENAB, 16'h7fff);
    wr(SEL_RUN_ENAB, 16'h7fd8);
    wr(4'hc, 16'h1234);
    for (int s = 0; s < 13; s++) rd(4'(s));
    $display("test writes done");
    for (int i = 0; i < 40; i++) begin
      for (int s = 2; s < 10; s++) if (s % 5 > 1) wr(4'(s), 16'($random(seed)) & 16'h7fff);
      pins(i[0], 16'($random(seed)));
      sums;
      rd(i[0] ? SEL_RUN_COND : SEL_FAULT_COND);
      rd(i[0] ? SEL_RUN_EVENT : SEL_FAULT_EVENT);
      rd(i[0] ? SEL_RUN_EVENT : SEL_FAULT_EVENT);
      sums;
    end
    $display("test filters done");
    wr(SEL_FAULT_FALL, FAULT_MASK);
    wr(SEL_FAULT_RISE, FAULT_MASK);
    wr(SEL_FAULT_ENAB, 16'h0001);
    rd(SEL_FAULT_EVENT);
    @(negedge mclk);
    fp = fp ^ 16'h0001;
    m[0] = fp & FAULT_MASK;
    // the edge reaches the event register at the very edge that takes this read
    repeat (3) @(negedge mclk);
    rd(SEL_FAULT_EVENT);
    m[1] = 16'h0001;
    sums;
    rd(SEL_FAULT_EVENT);
    rd(SEL_FAULT_COND);
    sums;
    $display("test read race done");
    @(negedge mclk);
    stat_preset = 1;
    @(negedge mclk);
    stat_preset = 0;
    foreach (m[s]) if (s % 5 > 1) m[s] = pv(s);
    for (int s = 0; s < 10; s++) rd(4'(s));
    sums;
    $display("test preset done");
    repeat (3) @(negedge mclk);
    chk("pending reads", 16'h0, 16'(exq.size()));
    wrap_up;
  end
  initial begin
    #800000;
    bad_count++;
    wrap_up;
  end
endmodule : tb_top
bind stef_top stef_props u_props (.mclk, .sys_rst, .cmd_sel, .cmd_wr, .cmd_rd, .stat_preset, .rsp_rdata,
  .rsp_valid, .fault_group_summary, .run_group_summary);
